// file: rtl/acr_pkg.sv
// shared constants, types and helpers of the configuration register control block
package acr_pkg;

  // ---------------------------------------------------------------
  // register pointer values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACR_PTR_CONV_DATA = 8'h00;
  localparam logic [7:0] ACR_PTR_CONFIG = 8'h01;

  // ---------------------------------------------------------------
  // field layout of the configuration word
  // ---------------------------------------------------------------
  localparam int ACR_TRIG_BIT = 15;
  localparam int ACR_MUX_LSB = 12;
  localparam int ACR_GAIN_LSB = 9;
  localparam int ACR_MODE_BIT = 8;
  localparam int ACR_RATE_LSB = 5;
  localparam int ACR_RSVD_W = 5;

  // ---------------------------------------------------------------
  // reset values and field codes
  // ---------------------------------------------------------------
  localparam logic ACR_TRIG_IDLE = 1'b1;
  localparam logic [2:0] ACR_MUX_RST = 3'h0;
  localparam logic [2:0] ACR_GAIN_RST = 3'h2;
  localparam logic ACR_MODE_SINGLE = 1'b1;
  localparam logic ACR_MODE_CONT = 1'b0;
  localparam logic [2:0] ACR_RATE_RST = 3'h4;
  localparam logic [4:0] ACR_RSVD_RST = 5'h03;
  localparam logic [2:0] ACR_GAIN_SMALLEST = 3'h5;
  localparam logic [2:0] ACR_RATE_FASTEST = 3'h6;
  localparam logic [1:0] ACR_IN_0 = 2'h0;
  localparam logic [1:0] ACR_IN_1 = 2'h1;
  localparam logic [1:0] ACR_IN_3 = 2'h3;
  localparam logic [15:0] ACR_WORD_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned ACR_CLK_HZ = 200_000_000;
  localparam int ACR_CNT_W = 24;
  localparam int unsigned ACR_RATE_SPS [8] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {ACR_IDLE, ACR_CONV} acr_conv_e;

  typedef struct packed {
    logic [2:0] mux;
    logic [2:0] gain;
    logic mode;
    logic [2:0] rate;
    logic [4:0] rsvd;
  } acr_cfg_s;

  typedef struct packed {
    logic [1:0] pos_sel;
    logic [1:0] neg_sel;
    logic neg_gnd;
    logic [2:0] fsr_code;
    logic [2:0] rate_code;
  } acr_sel_s;

  localparam acr_cfg_s ACR_CFG_RST = '{
    mux: ACR_MUX_RST, gain: ACR_GAIN_RST, mode: ACR_MODE_SINGLE,
    rate: ACR_RATE_RST, rsvd: ACR_RSVD_RST};

  function automatic logic [15:0] acr_cfg_word(input logic trig, input acr_cfg_s c);
    acr_cfg_word = {trig, c.mux, c.gain, c.mode, c.rate, c.rsvd};
  endfunction

  localparam logic [15:0] ACR_CFG_WORD_RST = acr_cfg_word(ACR_TRIG_IDLE, ACR_CFG_RST);

endpackage

// file: rtl/acr_sync.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module acr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acr_sync_s;

  acr_sync_s st_q;
  acr_sync_s st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// file: rtl/acr_config_ctrl.sv
// configuration register, conversion sequencing and link byte access
`timescale 1ns/1ps
module acr_config_ctrl
  import acr_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = ACR_CLK_HZ,
  parameter bit HAS_MUX = 1'b1,
  parameter bit HAS_GAIN = 1'b1
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic LINK_CLK,
  input wire logic LINK_WR_START,
  input wire logic LINK_WR_VALID,
  input wire logic [7:0] LINK_WR_BYTE,
  input wire logic LINK_RD_START,
  input wire logic LINK_RD_REQ,
  output logic [7:0] LINK_RD_BYTE,
  output logic CONV_ACTIVE,
  output logic CONV_DONE,
  output logic [1:0] POS_SEL,
  output logic [1:0] NEG_SEL,
  output logic NEG_GND,
  output logic [2:0] FSR_CODE,
  output logic [2:0] RATE_CODE
);

  // ---------------------------------------------------------------
  // state records
  // ---------------------------------------------------------------
  typedef struct packed {
    acr_cfg_s cfg;
    acr_conv_e st;
    logic [ACR_CNT_W-1:0] cnt;
    logic done;
    logic active;
    logic wr_seen;
    logic [15:0] rb;
    logic rb_tog;
    acr_sel_s sel;
  } acr_core_s;

  typedef struct packed {
    logic [1:0] idx;
    logic [7:0] ptr;
    logic [7:0] msb;
    logic [15:0] wr_word;
    logic wr_tog;
    logic rb_seen;
    logic [15:0] cfg_rd;
    logic rd_lsb;
    logic [7:0] rd_byte;
  } acr_link_s;

  localparam acr_sel_s SEL_RST = '{
    pos_sel: ACR_IN_0, neg_sel: ACR_IN_1, neg_gnd: 1'b0,
    fsr_code: ACR_GAIN_RST, rate_code: ACR_RATE_RST};

  acr_core_s c_q;
  acr_core_s c_d;
  acr_link_s l_q;
  acr_link_s l_d;
  logic wr_tog_s;
  logic rb_tog_s;
  logic wr_take;
  logic start;
  logic [15:0] rd_word;

  // longest time rounds down; count runs len-1 down to zero
  function automatic logic [ACR_CNT_W-1:0] conv_len(input logic [2:0] r);
    conv_len = ACR_CNT_W'(CLK_FREQ_HZ / ACR_RATE_SPS[r] - 1);
  endfunction

  // ---------------------------------------------------------------
  // domain crossings
  // ---------------------------------------------------------------
  // words are held still by their owner until the matching toggle is seen
  acr_sync #(.W(1)) u_wr_sync (
    .clk(MCLK),
    .rstn(RSTN),
    .d(l_q.wr_tog),
    .q(wr_tog_s)
  );

  acr_sync #(.W(1)) u_rb_sync (
    .clk(LINK_CLK),
    .rstn(RSTN),
    .d(c_q.rb_tog),
    .q(rb_tog_s)
  );

  // ---------------------------------------------------------------
  // core domain
  // ---------------------------------------------------------------
  always_comb begin
    c_d = c_q;
    c_d.done = 1'b0;
    wr_take = (wr_tog_s != c_q.wr_seen);
    c_d.wr_seen = wr_tog_s;
    start = 1'b0;
    if (wr_take) begin
      c_d.cfg.mux = HAS_MUX ? l_q.wr_word[ACR_MUX_LSB +: 3] : ACR_MUX_RST;
      c_d.cfg.gain = HAS_GAIN ? l_q.wr_word[ACR_GAIN_LSB +: 3] : ACR_GAIN_RST;
      c_d.cfg.mode = l_q.wr_word[ACR_MODE_BIT];
      c_d.cfg.rate = l_q.wr_word[ACR_RATE_LSB +: 3];
      c_d.cfg.rsvd = l_q.wr_word[ACR_RSVD_W-1:0];
    end
    case (c_q.st)
      ACR_IDLE: begin
        // trigger only counts while powered down; zero starts nothing unless continuous mode is set
        start = (wr_take && l_q.wr_word[ACR_TRIG_BIT]) || (c_d.cfg.mode == ACR_MODE_CONT);
      end
      ACR_CONV: begin
        if (c_q.cnt == '0) begin
          c_d.done = 1'b1;
          // leaving continuous mode lets the running conversion finish first
          if (c_d.cfg.mode == ACR_MODE_CONT) begin
            start = 1'b1;
          end else begin
            c_d.st = ACR_IDLE;
          end
        end else begin
          c_d.cnt = c_q.cnt - 1'b1;
        end
      end
      default: begin
        c_d.st = ACR_IDLE;
      end
    endcase
    if (start) begin
      c_d.st = ACR_CONV;
      c_d.cnt = conv_len(c_d.cfg.rate);
    end
    // registered copy keeps the busy output straight off a flop
    c_d.active = (c_d.st == ACR_CONV);
    // analog selection outputs
    if (c_d.cfg.mux[2]) begin
      c_d.sel.pos_sel = c_d.cfg.mux[1:0];
      c_d.sel.neg_sel = ACR_IN_0;
      c_d.sel.neg_gnd = 1'b1;
    end else if (c_d.cfg.mux[1:0] == ACR_IN_0) begin
      c_d.sel.pos_sel = ACR_IN_0;
      c_d.sel.neg_sel = ACR_IN_1;
      c_d.sel.neg_gnd = 1'b0;
    end else begin
      c_d.sel.pos_sel = c_d.cfg.mux[1:0] - 1'b1;
      c_d.sel.neg_sel = ACR_IN_3;
      c_d.sel.neg_gnd = 1'b0;
    end
    c_d.sel.fsr_code = (c_d.cfg.gain > ACR_GAIN_SMALLEST) ? ACR_GAIN_SMALLEST : c_d.cfg.gain;
    c_d.sel.rate_code = (c_d.cfg.rate > ACR_RATE_FASTEST) ? ACR_RATE_FASTEST : c_d.cfg.rate;
    // readback word published to the link on every change
    c_d.rb = acr_cfg_word(c_d.st != ACR_CONV, c_d.cfg);
    if (c_d.rb != c_q.rb) begin
      c_d.rb_tog = ~c_q.rb_tog;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      c_q <= '{cfg: ACR_CFG_RST, st: ACR_IDLE, cnt: '0, done: 1'b0, active: 1'b0,
               wr_seen: 1'b0, rb: ACR_CFG_WORD_RST, rb_tog: 1'b0, sel: SEL_RST};
    end else begin
      c_q <= c_d;
    end
  end

  // ---------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------
  always_comb begin
    l_d = l_q;
    rd_word = (l_q.ptr == ACR_PTR_CONFIG) ? l_q.cfg_rd : ACR_WORD_ZERO;
    l_d.rb_seen = rb_tog_s;
    if (rb_tog_s != l_q.rb_seen) begin
      l_d.cfg_rd = c_q.rb;
    end
    if (LINK_WR_START) begin
      l_d.idx = 2'h0;
    end else if (LINK_WR_VALID) begin
      case (l_q.idx)
        2'h0: begin
          l_d.ptr = LINK_WR_BYTE;
          l_d.idx = 2'h1;
        end
        2'h1: begin
          l_d.msb = LINK_WR_BYTE;
          l_d.idx = 2'h2;
        end
        2'h2: begin
          // only the configuration pointer takes data; extra bytes are dropped
          if (l_q.ptr == ACR_PTR_CONFIG) begin
            l_d.wr_word = {l_q.msb, LINK_WR_BYTE};
            l_d.wr_tog = ~l_q.wr_tog;
          end
          l_d.idx = 2'h3;
        end
        default: begin
          l_d.idx = 2'h3;
        end
      endcase
    end
    if (LINK_RD_START) begin
      l_d.rd_lsb = 1'b0;
    end else if (LINK_RD_REQ) begin
      l_d.rd_byte = l_q.rd_lsb ? rd_word[7:0] : rd_word[15:8];
      l_d.rd_lsb = ~l_q.rd_lsb;
    end
  end

  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      l_q <= '{idx: 2'h3, ptr: ACR_PTR_CONV_DATA, msb: '0, wr_word: '0, wr_tog: 1'b0,
               rb_seen: 1'b0, cfg_rd: ACR_CFG_WORD_RST, rd_lsb: 1'b0, rd_byte: '0};
    end else begin
      l_q <= l_d;
    end
  end

  assign LINK_RD_BYTE = l_q.rd_byte;
  assign CONV_ACTIVE = c_q.active;
  assign CONV_DONE = c_q.done;
  assign POS_SEL = c_q.sel.pos_sel;
  assign NEG_SEL = c_q.sel.neg_sel;
  assign NEG_GND = c_q.sel.neg_gnd;
  assign FSR_CODE = c_q.sel.fsr_code;
  assign RATE_CODE = c_q.sel.rate_code;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_trig_start: assert property (@(posedge MCLK) disable iff (!RSTN)
    (c_q.st == ACR_IDLE && wr_take && l_q.wr_word[ACR_TRIG_BIT])
    |=> (c_q.st == ACR_CONV) ##1 (c_q.st == ACR_CONV))
    else $error("trigger write while idle did not start a conversion");

  chk_trig_busy: assert property (@(posedge MCLK) disable iff (!RSTN)
    (c_q.st == ACR_CONV && c_q.cnt > 1 && wr_take) |=> (c_q.cnt == $past(c_q.cnt) - 1'b1))
    else $error("write during conversion disturbed the running count");

  chk_zero_trig: assert property (@(posedge MCLK) disable iff (!RSTN)
    (c_q.st == ACR_IDLE && wr_take && !l_q.wr_word[ACR_TRIG_BIT] && l_q.wr_word[ACR_MODE_BIT])
    |=> (c_q.st == ACR_IDLE))
    else $error("zero trigger write started a conversion");

  chk_status_read: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(CONV_ACTIVE) |-> !c_q.rb[ACR_TRIG_BIT] ##1 !c_q.rb[ACR_TRIG_BIT])
    else $error("status bit not low while converting");

  chk_pair_map: assert property (@(posedge MCLK) disable iff (!RSTN)
    (c_q.cfg.mux[2] == 1'b0 && c_q.cfg.mux[1:0] != ACR_IN_0)
    |-> (NEG_SEL == ACR_IN_3 && !NEG_GND && POS_SEL == c_q.cfg.mux[1:0] - 1'b1))
    else $error("differential pair decode wrong");

  chk_single_end: assert property (@(posedge MCLK) disable iff (!RSTN)
    c_q.cfg.mux[2] |-> (NEG_GND && POS_SEL == c_q.cfg.mux[1:0]))
    else $error("single-ended decode wrong");

  chk_mux_fixed: assert property (@(posedge MCLK) disable iff (!RSTN)
    !HAS_MUX |-> (c_q.cfg.mux == ACR_MUX_RST && c_q.rb[ACR_MUX_LSB +: 3] == ACR_MUX_RST))
    else $error("input select moved on single-channel variant");

  chk_gain_map: assert property (@(posedge MCLK) disable iff (!RSTN)
    (c_q.cfg.gain >= ACR_GAIN_SMALLEST) |-> (FSR_CODE == ACR_GAIN_SMALLEST))
    else $error("smallest range codes not folded");

  chk_gain_fixed: assert property (@(posedge MCLK) disable iff (!RSTN)
    !HAS_GAIN |-> (c_q.cfg.gain == ACR_GAIN_RST))
    else $error("gain field moved on gainless variant");

  chk_cont_mode: assert property (@(posedge MCLK) disable iff (!RSTN)
    (c_q.cfg.mode == ACR_MODE_CONT && CONV_DONE) |-> CONV_ACTIVE)
    else $error("continuous mode stopped after a conversion");

  chk_rate_len: assert property (@(posedge MCLK) disable iff (!RSTN)
    (c_q.st == ACR_IDLE && c_d.st == ACR_CONV) |=> (c_q.cnt == conv_len(c_q.cfg.rate)))
    else $error("conversion length does not match rate");

  chk_ptr_select: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (LINK_WR_VALID && !LINK_WR_START && l_q.idx == 2'h2)
    |=> (l_q.wr_tog != $past(l_q.wr_tog)) == ($past(l_q.ptr) == ACR_PTR_CONFIG))
    else $error("data write not gated by configuration pointer");

  chk_single_stop: assert property (@(posedge MCLK) disable iff (!RSTN)
    (CONV_DONE && c_q.cfg.mode == ACR_MODE_SINGLE) |-> !CONV_ACTIVE)
    else $error("single-shot conversion did not stop after one result");

  chk_rate_fold: assert property (@(posedge MCLK) disable iff (!RSTN)
    (c_q.cfg.rate == 3'h7) |-> (RATE_CODE == ACR_RATE_FASTEST))
    else $error("top rate code not folded");

endmodule

// file: testbench/acr_host_model.sv
// link-side host model driving the configuration byte interface
`timescale 1ns/1ps
module acr_host_model (
  input wire logic link_clk,
  output logic wr_start,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_start,
  output logic rd_req,
  input wire logic [7:0] rd_byte
);
  initial begin
    wr_start = 1'b0;
    wr_valid = 1'b0;
    wr_byte = 8'h00;
    rd_start = 1'b0;
    rd_req = 1'b0;
  end

  // ---------------------------------------------------------------
  // write frame: pointer, then msb and lsb when full is set
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] ptr, input logic [15:0] w, input logic full);
    @(negedge link_clk) wr_start = 1'b1;
    @(negedge link_clk) begin
      wr_start = 1'b0;
      wr_valid = 1'b1;
      wr_byte = ptr;
    end
    if (full) begin
      @(negedge link_clk) wr_byte = w[15:8];
      @(negedge link_clk) wr_byte = w[7:0];
    end
    // released byte lane flips so a stale value never looks valid
    @(negedge link_clk) begin
      wr_valid = 1'b0;
      wr_byte = ~wr_byte;
    end
  endtask

  // ---------------------------------------------------------------
  // read frame: pointer setup, then msb and lsb
  // ---------------------------------------------------------------
  task automatic rd(input logic [7:0] ptr, output logic [15:0] w);
    wr(ptr, 16'h0000, 1'b0);
    @(negedge link_clk) rd_start = 1'b1;
    @(negedge link_clk) begin
      rd_start = 1'b0;
      rd_req = 1'b1;
    end
    // msb was registered at the edge just passed; request stays up for the lsb
    @(negedge link_clk) w[15:8] = rd_byte;
    @(negedge link_clk) begin
      rd_req = 1'b0;
      w[7:0] = rd_byte;
    end
  endtask
endmodule

// file: testbench/acr_config_ctrl_tb.sv
// self-checking bench for the configuration register control block
`timescale 1ns/1ps
module acr_config_ctrl_tb;
  import acr_pkg::*;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_start, wr_valid, rd_start, rd_req;
  logic [7:0] wr_byte, rd_byte;
  logic conv_active, conv_done, neg_gnd;
  logic [1:0] pos_sel, neg_sel;
  logic [2:0] fsr_code, rate_code;
  logic [1:0] v_pos, v_neg;
  logic v_gnd;
  logic [2:0] v_fsr;
  logic [15:0] w, cw;
  int fails = 0;
  int n_tests = 0;
  int n_done = 0;
  int c0;

  initial forever #2.5 mclk = ~mclk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  always @(negedge mclk) if (conv_done === 1'b1) n_done++;

  // shortened conversions: 1000 cycles at the slowest rate
  acr_config_ctrl #(.CLK_FREQ_HZ(128000)) i_acr_config_ctrl (
    .MCLK(mclk), .RSTN(rstn), .LINK_CLK(link_clk),
    .LINK_WR_START(wr_start), .LINK_WR_VALID(wr_valid), .LINK_WR_BYTE(wr_byte),
    .LINK_RD_START(rd_start), .LINK_RD_REQ(rd_req), .LINK_RD_BYTE(rd_byte),
    .CONV_ACTIVE(conv_active), .CONV_DONE(conv_done), .POS_SEL(pos_sel),
    .NEG_SEL(neg_sel), .NEG_GND(neg_gnd), .FSR_CODE(fsr_code), .RATE_CODE(rate_code));

  acr_host_model i_acr_host_model (
    .link_clk(link_clk), .wr_start(wr_start), .wr_valid(wr_valid), .wr_byte(wr_byte),
    .rd_start(rd_start), .rd_req(rd_req), .rd_byte(rd_byte));

  // single-channel, gainless build fed by the same host lines
  acr_config_ctrl #(.CLK_FREQ_HZ(128000), .HAS_MUX(1'b0), .HAS_GAIN(1'b0)) i_acr_config_ctrl_min (
    .MCLK(mclk), .RSTN(rstn), .LINK_CLK(link_clk),
    .LINK_WR_START(wr_start), .LINK_WR_VALID(wr_valid), .LINK_WR_BYTE(wr_byte),
    .LINK_RD_START(rd_start), .LINK_RD_REQ(rd_req), .LINK_RD_BYTE(),
    .CONV_ACTIVE(), .CONV_DONE(), .POS_SEL(v_pos),
    .NEG_SEL(v_neg), .NEG_GND(v_gnd), .FSR_CODE(v_fsr), .RATE_CODE());

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_done(input int max);
    int k;
    k = 0;
    while (conv_done !== 1'b1 && k < max) begin
      @(negedge mclk);
      k++;
    end
    if (conv_done !== 1'b1) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
      report_and_stop();
    end
  endtask

  function automatic logic [15:0] sel_now();
    sel_now = {5'h00, pos_sel, neg_sel, neg_gnd, fsr_code, rate_code};
  endfunction

  // expected routing for one code used in all three fields
  function automatic logic [15:0] exp_sel(input logic [2:0] c);
    logic [1:0] p;
    logic [1:0] n;
    p = c[2] ? c[1:0] : ((c == 3'h0) ? 2'h0 : 2'(c - 3'h1));
    n = c[2] ? 2'h0 : ((c == 3'h0) ? 2'h1 : 2'h3);
    exp_sel = {5'h00, p, n, c[2], ((c > 3'h5) ? 3'h5 : c), ((c == 3'h7) ? 3'h6 : c)};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    wt(8);
    rstn = 1'b1;
    wt(4);
    i_acr_host_model.rd(8'h01, w);
    chk(w, 16'h8583);
    chk(sel_now(), {5'h00, 2'h0, 2'h1, 1'b0, 3'h2, 3'h4});
    for (int i = 0; i < 8; i++) begin
      // trigger left at 0 and reserved bits at 00011
      cw = {1'b0, 3'(i), 3'(i), 1'b1, 3'(i), 5'h03};
      i_acr_host_model.wr(8'h01, cw, 1'b1);
      wt(12);
      chk(sel_now(), exp_sel(3'(i)));
      chk({8'h00, v_pos, v_neg, v_gnd, v_fsr}, {8'h00, 2'h0, 2'h1, 1'b0, 3'h2});
      i_acr_host_model.rd(8'h01, w);
      chk(w, cw | 16'h8000);
    end
    chk({15'h0000, conv_active}, 16'h0000);
    chk(16'(n_done), 16'h0000);
    // single shot at the slowest rate, retrigger while busy
    i_acr_host_model.wr(8'h01, 16'h8503, 1'b1);
    wt(12);
    chk({15'h0000, conv_active}, 16'h0001);
    i_acr_host_model.rd(8'h01, w);
    chk(w, 16'h0503);
    i_acr_host_model.wr(8'h01, 16'h8703, 1'b1);
    wt(12);
    chk(16'(fsr_code), 16'h0003);
    wait_done(1100);
    wt(100);
    chk({15'h0000, conv_active}, 16'h0000);
    chk(16'(n_done), 16'h0001);
    i_acr_host_model.rd(8'h01, w);
    chk(w, 16'h8703);
    // continuous at the fastest rate, then back to single shot
    c0 = n_done;
    i_acr_host_model.wr(8'h01, 16'h04C3, 1'b1);
    wt(200);
    chk(16'(n_done - c0 >= 4), 16'h0001);
    i_acr_host_model.wr(8'h01, 16'h05C3, 1'b1);
    wt(60);
    chk({15'h0000, conv_active}, 16'h0000);
    // data write through the wrong pointer is dropped
    i_acr_host_model.wr(8'h00, 16'h1234, 1'b1);
    wt(12);
    i_acr_host_model.rd(8'h00, w);
    chk(w, 16'h0000);
    i_acr_host_model.rd(8'h01, w);
    chk(w, 16'h85C3);
    report_and_stop();
  end
endmodule
